// *** src/cpurf_pkg.sv ***
/*
  cpurf_pkg: constants for the processor register file (register map,
  flag field positions, reset values, register and access-size codes).
  assumes: used by cpurf_top and tb_top, always referenced as cpurf_pkg::name.
*/
package cpurf_pkg;

  // axi byte offsets, one aligned word per register
  localparam logic [7:0] OFS_BANK0 = 8'h00;  // data 0..3, address 0..1, frame base
  localparam logic [7:0] OFS_BANK1 = 8'h20;
  localparam logic [7:0] OFS_VTB   = 8'h40;
  localparam logic [7:0] OFS_PC    = 8'h44;
  localparam logic [7:0] OFS_USTK  = 8'h48;
  localparam logic [7:0] OFS_ISTK  = 8'h4c;
  localparam logic [7:0] OFS_SBASE = 8'h50;
  localparam logic [7:0] OFS_FLAGS = 8'h54;
  localparam logic [7:0] OFS_STAT  = 8'h58;

  localparam int NUM_BANKS  = 2;
  localparam int BANK_REGS  = 7;
  localparam int WORD_W     = 16;
  localparam int ADDR20_W   = 20;
  localparam int FLAG_W     = 11;
  localparam logic [5:0] SWI_STACK_LIMIT = 6'h20;  // numbers 0..31 switch stack

  // flag field positions
  localparam int FL_C      = 0;
  localparam int FL_D      = 1;
  localparam int FL_Z      = 2;
  localparam int FL_S      = 3;
  localparam int FL_B      = 4;
  localparam int FL_O      = 5;
  localparam int FL_I      = 6;
  localparam int FL_U      = 7;
  localparam int FL_LVL_LO = 8;
  localparam int FL_LVL_HI = 10;

  // alu flag update mask bits
  localparam int UPD_C = 0;
  localparam int UPD_Z = 1;
  localparam int UPD_S = 2;
  localparam int UPD_O = 3;

  localparam logic [15:0]   RST_WORD = 16'h0000;
  localparam logic [19:0]   RST_ADDR = 20'h00000;
  localparam logic [10:0]   RST_FLAGS = 11'h000;
  localparam logic [1:0]    RESP_OKAY   = 2'h0;
  localparam logic [1:0]    RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    SEL_D0, SEL_D1, SEL_D2, SEL_D3, SEL_AD0, SEL_AD1, SEL_FBASE,
    SEL_SBASE, SEL_SP, SEL_VTB, SEL_PC, SEL_FLAGS
  } cpurf_sel_e;

  typedef enum logic [1:0] {
    SZ_WORD, SZ_LOW_BYTE, SZ_HIGH_BYTE, SZ_LONG
  } cpurf_size_e;

endpackage

// *** src/cpurf_top.sv ***
/*
  cpurf_top: programmer-visible register set of a 16-bit core, with an
  execution-unit port, an alu flag port and an axi4-lite slave.
  assumes: one clock aclk, synchronous active-low aresetn, execution unit
  inputs synchronous to aclk.
*/
`timescale 1ns/1ps
module cpurf_top (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // execution unit register port
  input  wire logic        ex_wr_en,
  input  wire logic [3:0]  ex_wr_sel,
  input  wire logic [1:0]  ex_wr_size,
  input  wire logic [31:0] ex_wr_data,
  input  wire logic [3:0]  ex_rd_sel,
  input  wire logic [1:0]  ex_rd_size,
  output logic      [31:0] ex_rd_data,
  output logic      [19:0] pc_value,
  output logic      [19:0] vtb_value,
  // alu flag port
  input  wire logic        alu_flag_en,
  input  wire logic [3:0]  alu_flag_mask,
  input  wire logic [1:0]  alu_size,
  input  wire logic [31:0] alu_result,
  input  wire logic        alu_carry,
  input  wire logic        alu_overflow,
  // interrupt control
  input  wire logic        irq_ack,
  input  wire logic        swi_exec,
  input  wire logic [5:0]  swi_num,
  input  wire logic [2:0]  irq_level,
  output logic             irq_enabled,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  logic [15:0] bank_ff [cpurf_pkg::NUM_BANKS][cpurf_pkg::BANK_REGS];
  logic [19:0] vtb_ff;
  logic [19:0] pc_ff;
  logic [15:0] ustk_ff;
  logic [15:0] istk_ff;
  logic [15:0] sbase_ff;
  logic [10:0] flags_ff;
  logic [31:0] ex_rd_data_ff;

  logic        aw_got_ff;
  logic        w_got_ff;
  logic [7:0]  aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0]  w_strb_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;

  logic        cur_bank;
  logic        sw_wr;
  logic [2:0]  cur_level;

  // bank and stack flags are read straight from the flag flops, so a flag
  // write lands first and every later access sees the new selection
  assign cur_bank  = flags_ff[cpurf_pkg::FL_B];
  assign cur_level = flags_ff[cpurf_pkg::FL_LVL_HI:cpurf_pkg::FL_LVL_LO];
  assign irq_enabled = flags_ff[cpurf_pkg::FL_I] && (irq_level > cur_level);

  assign ex_rd_data = ex_rd_data_ff;
  assign pc_value   = pc_ff;
  assign vtb_value  = vtb_ff;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int k = 0; k < 4; k++)
    begin
      if (strb[k])
        r[8*k +: 8] = new_v[8*k +: 8];
    end
    return r;
  endfunction

  function automatic logic sw_map_ok(input logic [7:0] a);
    logic ok;
    ok = (a < cpurf_pkg::OFS_BANK0 + 8'h1c) ||
         ((a >= cpurf_pkg::OFS_BANK1) && (a < cpurf_pkg::OFS_BANK1 + 8'h1c)) ||
         ((a >= cpurf_pkg::OFS_VTB) && (a <= cpurf_pkg::OFS_STAT));
    return ok && (a[1:0] == 2'h0);
  endfunction

  // axi write channel: address and data taken in either order
  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready  = !w_got_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign sw_wr = aw_got_ff && w_got_ff && !bvalid_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff  <= 32'h0000_0000;
      w_strb_ff  <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= cpurf_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_ff  <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_ff  <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (sw_wr)
      begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= sw_map_ok(aw_addr_ff) ? cpurf_pkg::RESP_OKAY : cpurf_pkg::RESP_SLVERR;
      end
      else if (bvalid_ff && s_axi_bready)
        bvalid_ff <= 1'b0;
    end
  end

  // axi read channel, one read at a time
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  function automatic logic [31:0] sw_read(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a < cpurf_pkg::OFS_BANK0 + 8'h1c)
      v = {16'h0000, bank_ff[0][a[4:2]]};
    else if ((a >= cpurf_pkg::OFS_BANK1) && (a < cpurf_pkg::OFS_BANK1 + 8'h1c))
      v = {16'h0000, bank_ff[1][a[4:2]]};
    else
    begin
      unique case (a)
        cpurf_pkg::OFS_VTB:  v = {12'h000, vtb_ff};
        cpurf_pkg::OFS_PC:   v = {12'h000, pc_ff};
        cpurf_pkg::OFS_USTK:  v = {16'h0000, ustk_ff};
        cpurf_pkg::OFS_ISTK:  v = {16'h0000, istk_ff};
        cpurf_pkg::OFS_SBASE: v = {16'h0000, sbase_ff};
        cpurf_pkg::OFS_FLAGS: v = {21'h00000, flags_ff};
        cpurf_pkg::OFS_STAT:  v = {29'h0000000, irq_enabled, flags_ff[cpurf_pkg::FL_U],
                                  cur_bank};
        default:             v = 32'h0000_0000;
      endcase
    end
    return v;
  endfunction

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= cpurf_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= sw_map_ok(s_axi_araddr) ? sw_read(s_axi_araddr) : 32'h0000_0000;
      rresp_ff  <= sw_map_ok(s_axi_araddr) ? cpurf_pkg::RESP_OKAY : cpurf_pkg::RESP_SLVERR;
    end
    else if (rvalid_ff && s_axi_rready)
      rvalid_ff <= 1'b0;
  end

  // banked registers; the execution unit overrides software in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int b = 0; b < cpurf_pkg::NUM_BANKS; b++)
        for (int i = 0; i < cpurf_pkg::BANK_REGS; i++)
          bank_ff[b][i] <= cpurf_pkg::RST_WORD;
    end
    else
    begin
      for (int b = 0; b < cpurf_pkg::NUM_BANKS; b++)
      begin
        for (int i = 0; i < cpurf_pkg::BANK_REGS; i++)
        begin
          if (sw_wr && (aw_addr_ff == (b == 0 ? cpurf_pkg::OFS_BANK0 : cpurf_pkg::OFS_BANK1)
                                       + 8'(4 * i)))
            bank_ff[b][i] <= 16'(merge({16'h0000, bank_ff[b][i]}, w_data_ff, w_strb_ff));
          if (ex_wr_en && (b == int'(cur_bank)) && (int'(ex_wr_sel) == i))
          begin
            unique case (ex_wr_size)
              cpurf_pkg::SZ_LOW_BYTE:
                if (i < 2)
                  bank_ff[b][i][7:0] <= ex_wr_data[7:0];
              cpurf_pkg::SZ_HIGH_BYTE:
                if (i < 2)
                  bank_ff[b][i][15:8] <= ex_wr_data[7:0];
              default:
                bank_ff[b][i] <= ex_wr_data[15:0];
            endcase
          end
          // long writes: data 2/3 over data 0/1, address 1 over address 0
          if (ex_wr_en && (b == int'(cur_bank)) && (ex_wr_size == cpurf_pkg::SZ_LONG) &&
              (((i == 2 || i == 3) && (int'(ex_wr_sel) == i - 2)) ||
               ((i == 5) && (ex_wr_sel == cpurf_pkg::SEL_AD0))))
            bank_ff[b][i] <= ex_wr_data[31:16];
        end
      end
    end
  end

  // shared registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      vtb_ff <= cpurf_pkg::RST_ADDR;
      pc_ff  <= cpurf_pkg::RST_ADDR;
      ustk_ff  <= cpurf_pkg::RST_WORD;
      istk_ff  <= cpurf_pkg::RST_WORD;
      sbase_ff <= cpurf_pkg::RST_WORD;
    end
    else
    begin
      if (sw_wr)
      begin
        unique case (aw_addr_ff)
          cpurf_pkg::OFS_VTB:
            vtb_ff <= 20'(merge({12'h000, vtb_ff}, w_data_ff, w_strb_ff));
          cpurf_pkg::OFS_PC:
            pc_ff <= 20'(merge({12'h000, pc_ff}, w_data_ff, w_strb_ff));
          cpurf_pkg::OFS_USTK:
            ustk_ff <= 16'(merge({16'h0000, ustk_ff}, w_data_ff, w_strb_ff));
          cpurf_pkg::OFS_ISTK:
            istk_ff <= 16'(merge({16'h0000, istk_ff}, w_data_ff, w_strb_ff));
          cpurf_pkg::OFS_SBASE:
            sbase_ff <= 16'(merge({16'h0000, sbase_ff}, w_data_ff, w_strb_ff));
          default:            ;
        endcase
      end
      if (ex_wr_en)
      begin
        unique case (ex_wr_sel)
          cpurf_pkg::SEL_VTB: vtb_ff <= ex_wr_data[19:0];
          cpurf_pkg::SEL_PC:  pc_ff  <= ex_wr_data[19:0];
          cpurf_pkg::SEL_SBASE: sbase_ff <= ex_wr_data[15:0];
          cpurf_pkg::SEL_SP:
            if (flags_ff[cpurf_pkg::FL_U])
              ustk_ff <= ex_wr_data[15:0];
            else
              istk_ff <= ex_wr_data[15:0];
          default:            ;
        endcase
      end
    end
  end

  // flag register; alu and interrupt updates win over plain writes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flags_ff <= cpurf_pkg::RST_FLAGS;
    else
    begin
      // the debug bit is stored as written; keeping it zero is the writer's job
      if (sw_wr && (aw_addr_ff == cpurf_pkg::OFS_FLAGS))
        flags_ff <= 11'(merge({21'h00000, flags_ff}, w_data_ff, w_strb_ff));
      if (ex_wr_en && (ex_wr_sel == cpurf_pkg::SEL_FLAGS))
        flags_ff <= ex_wr_data[10:0];
      if (alu_flag_en)
      begin
        if (alu_flag_mask[cpurf_pkg::UPD_C])
          flags_ff[cpurf_pkg::FL_C] <= alu_carry;
        if (alu_flag_mask[cpurf_pkg::UPD_Z])
          flags_ff[cpurf_pkg::FL_Z] <= (alu_size == cpurf_pkg::SZ_LONG) ?
            (alu_result == 32'h0000_0000) :
            (alu_size == cpurf_pkg::SZ_WORD) ? (alu_result[15:0] == 16'h0000) :
            (alu_result[7:0] == 8'h00);
        if (alu_flag_mask[cpurf_pkg::UPD_S])
          flags_ff[cpurf_pkg::FL_S] <= (alu_size == cpurf_pkg::SZ_LONG) ?
            alu_result[31] :
            (alu_size == cpurf_pkg::SZ_WORD) ? alu_result[15] : alu_result[7];
        if (alu_flag_mask[cpurf_pkg::UPD_O])
          flags_ff[cpurf_pkg::FL_O] <= alu_overflow;
      end
      if (swi_exec && (swi_num < cpurf_pkg::SWI_STACK_LIMIT))
        flags_ff[cpurf_pkg::FL_U] <= 1'b0;
      if (irq_ack)
      begin
        flags_ff[cpurf_pkg::FL_I] <= 1'b0;
        flags_ff[cpurf_pkg::FL_U] <= 1'b0;
      end
    end
  end

  // registered read port of the execution unit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ex_rd_data_ff <= 32'h0000_0000;
    else
    begin
      ex_rd_data_ff <= 32'h0000_0000;
      unique case (ex_rd_sel)
        cpurf_pkg::SEL_VTB: ex_rd_data_ff <= {12'h000, vtb_ff};
        cpurf_pkg::SEL_PC:  ex_rd_data_ff <= {12'h000, pc_ff};
        cpurf_pkg::SEL_SBASE: ex_rd_data_ff <= {16'h0000, sbase_ff};
        cpurf_pkg::SEL_FLAGS: ex_rd_data_ff <= {21'h00000, flags_ff};
        cpurf_pkg::SEL_SP:    ex_rd_data_ff <= {16'h0000, flags_ff[cpurf_pkg::FL_U] ?
                                                ustk_ff : istk_ff};
        default:
          if (ex_rd_size == cpurf_pkg::SZ_LONG && ex_rd_sel < cpurf_pkg::SEL_D2)
            ex_rd_data_ff <= {bank_ff[cur_bank][ex_rd_sel[0] + 2'h2],
                              bank_ff[cur_bank][ex_rd_sel[0]]};
          else if (ex_rd_size == cpurf_pkg::SZ_LONG && ex_rd_sel == cpurf_pkg::SEL_AD0)
            ex_rd_data_ff <= {bank_ff[cur_bank][5], bank_ff[cur_bank][4]};
          else if (ex_rd_size == cpurf_pkg::SZ_HIGH_BYTE)
            ex_rd_data_ff <= {24'h000000, bank_ff[cur_bank][ex_rd_sel[2:0]][15:8]};
          else if (ex_rd_size == cpurf_pkg::SZ_LOW_BYTE)
            ex_rd_data_ff <= {24'h000000, bank_ff[cur_bank][ex_rd_sel[2:0]][7:0]};
          else
            ex_rd_data_ff <= {16'h0000, bank_ff[cur_bank][ex_rd_sel[2:0]]};
      endcase
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_carry_capture: assert property (alu_flag_en && alu_flag_mask[0] |=>
    flags_ff[cpurf_pkg::FL_C] == $past(alu_carry)) else $error("carry not captured");
  a_zero_word: assert property (alu_flag_en && alu_flag_mask[1] && alu_size == 2'h0 |=>
    flags_ff[cpurf_pkg::FL_Z] == ($past(alu_result[15:0]) == 16'h0000))
    else $error("zero flag wrong");
  a_sign_word: assert property (alu_flag_en && alu_flag_mask[2] && alu_size == 2'h0 |=>
    flags_ff[cpurf_pkg::FL_S] == $past(alu_result[15])) else $error("sign flag wrong");
  a_overflow_capture: assert property (alu_flag_en && alu_flag_mask[3] |=>
    flags_ff[cpurf_pkg::FL_O] == $past(alu_overflow)) else $error("overflow flag wrong");
  a_ack_clears_flags: assert property (irq_ack |=> !flags_ff[cpurf_pkg::FL_I] &&
    !flags_ff[cpurf_pkg::FL_U] && !irq_enabled) else $error("ack did not clear flags");
  a_swi_stack_sel: assert property (swi_exec && swi_num < 6'h20 |=>
    !flags_ff[cpurf_pkg::FL_U]) else $error("swi did not select interrupt stack");
  a_bank_route: assert property (ex_wr_en && ex_wr_sel == 4'h0 && ex_wr_size == 2'h0 |=>
    bank_ff[$past(cur_bank)][0] == $past(ex_wr_data[15:0])) else $error("bank routing wrong");
  a_long_pair_rd: assert property (
    ex_wr_en && ex_wr_sel == 4'h4 && ex_wr_size == 2'h3 ##1
    ex_rd_sel == 4'h4 && ex_rd_size == 2'h3 && $stable(cur_bank) |=>
    ex_rd_data == $past(ex_wr_data, 2)) else $error("long address pair wrong");
  a_priority_gate: assert property (irq_enabled |-> irq_level > cur_level)
    else $error("interrupt enabled at low priority");
  a_axi_bhold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");

  c_bank1_write: cover property (cur_bank && ex_wr_en);
  c_long_read: cover property (ex_rd_size == 2'h3 ##1 ex_rd_data != 32'h0000_0000);
  c_irq_ack: cover property (irq_enabled ##1 irq_ack);
  c_axi_write: cover property (s_axi_bvalid && s_axi_bready);

endmodule

// *** dv/cpurf_exec_model.sv ***
/*
  cpurf_exec_model: behavioural execution unit and alu facing the register
  file; register writes and reads, flag updates, interrupt events.
  assumes: shares aclk with cpurf_top; tasks are called one at a time.
*/
`timescale 1ns/1ps
module cpurf_exec_model (
  // clock
  input  wire logic        aclk,
  // register port
  output logic             ex_wr_en,
  output logic      [3:0]  ex_wr_sel,
  output logic      [1:0]  ex_wr_size,
  output logic      [31:0] ex_wr_data,
  output logic      [3:0]  ex_rd_sel,
  output logic      [1:0]  ex_rd_size,
  input  wire logic [31:0] ex_rd_data,
  // alu flags
  output logic             alu_flag_en,
  output logic      [3:0]  alu_flag_mask,
  output logic      [1:0]  alu_size,
  output logic      [31:0] alu_result,
  output logic             alu_carry,
  output logic             alu_overflow,
  // interrupt events
  output logic             irq_ack,
  output logic             swi_exec,
  output logic      [5:0]  swi_num,
  output logic      [2:0]  irq_level
);
  initial
  begin
    {ex_wr_en, ex_wr_sel, ex_wr_size, ex_wr_data, ex_rd_sel, ex_rd_size} = '0;
    {alu_flag_en, alu_flag_mask, alu_size, alu_result, alu_carry, alu_overflow} = '0;
    {irq_ack, swi_exec, swi_num, irq_level} = '0;
  end

  task automatic wr(input logic [3:0] s, input logic [1:0] z, input logic [31:0] d);
    @(posedge aclk);
    ex_wr_en   <= 1'b1;
    ex_wr_sel  <= s;
    ex_wr_size <= z;
    ex_wr_data <= (s == 4'hb) ? (d & ~32'h2) : d;
    @(posedge aclk);
    ex_wr_en   <= 1'b0;
    // released operand lines must not keep looking valid
    ex_wr_data <= ~d;
  endtask

  task automatic rd(input logic [3:0] s, input logic [1:0] z, output logic [31:0] v);
    @(posedge aclk);
    ex_rd_sel  <= s;
    ex_rd_size <= z;
    @(posedge aclk);
    #1;
    v = ex_rd_data;
  endtask

  task automatic alu(input logic [3:0] m, input logic [1:0] z, input logic [31:0] v,
                     input logic c, input logic o);
    @(posedge aclk);
    alu_flag_en   <= 1'b1;
    alu_flag_mask <= m;
    alu_size      <= z;
    alu_result    <= v;
    alu_carry     <= c;
    alu_overflow  <= o;
    @(posedge aclk);
    alu_flag_en   <= 1'b0;
    alu_result    <= ~v;
  endtask

  task automatic pulse(input logic a, input logic s, input logic [5:0] n);
    @(posedge aclk);
    irq_ack  <= a;
    swi_exec <= s;
    swi_num  <= n;
    @(posedge aclk);
    irq_ack  <= 1'b0;
    swi_exec <= 1'b0;
  endtask

  task automatic lvl(input logic [2:0] v);
    @(posedge aclk);
    irq_level <= v;
    #1;
  endtask
endmodule

// *** dv/tb_top.sv ***
/*
  tb_top: self-checking bench for cpurf_top; axi4-lite master, model array
  of the register map, execution-unit partner model.
  assumes: cpurf_pkg and cpurf_exec_model compiled first.
*/
`timescale 1ns/1ps
`define CK(g, e) \
  begin \
    checks++; \
    if ((g) !== (e)) \
    begin \
      bad_count++; \
      $display("[ERR] %0t got %h want %h", $time, g, e); \
    end \
  end
module tb_top;
  localparam logic [1:0] OK_R  = cpurf_pkg::RESP_OKAY;
  localparam logic [1:0] ERR_R = cpurf_pkg::RESP_SLVERR;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, ex_wr_en, alu_flag_en, alu_carry, alu_overflow, irq_ack;
  logic        swi_exec, irq_enabled;
  logic [1:0]  ex_wr_size, ex_rd_size, alu_size, s_axi_bresp, s_axi_rresp, r;
  logic [2:0]  irq_level;
  logic [3:0]  ex_wr_sel, ex_rd_sel, alu_flag_mask, s_axi_wstrb;
  logic [5:0]  swi_num;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [15:0] rs;
  logic [19:0] pc_value, vtb_value;
  logic [31:0] ex_wr_data, ex_rd_data, alu_result, s_axi_wdata, s_axi_rdata, d, v;
  int          bad_count, checks, cyc;
  int          m[22];

  cpurf_top cpurf_top_i (.aclk, .aresetn, .ex_wr_en, .ex_wr_sel, .ex_wr_size, .ex_wr_data,
    .ex_rd_sel, .ex_rd_size, .ex_rd_data, .pc_value, .vtb_value, .alu_flag_en, .alu_flag_mask,
    .alu_size, .alu_result, .alu_carry, .alu_overflow, .irq_ack, .swi_exec, .swi_num,
    .irq_level, .irq_enabled, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  cpurf_exec_model cpurf_exec_model_i (.aclk, .ex_wr_en, .ex_wr_sel, .ex_wr_size, .ex_wr_data,
    .ex_rd_sel, .ex_rd_size, .ex_rd_data, .alu_flag_en, .alu_flag_mask, .alu_size, .alu_result,
    .alu_carry, .alu_overflow, .irq_ack, .swi_exec, .swi_num, .irq_level);

  always #10 aclk = ~aclk;

  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [31:0] wmask(input int i);
    return (i == 16 || i == 17) ? 32'h000fffff : (i == 21) ? 32'h000007ff : 32'h0000ffff;
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] w);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= w;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask

  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    axr(a);
    `CK(d, e)
    `CK(r, OK_R)
  endtask

  task automatic sweep();
    for (int i = 0; i < 22; i++)
    begin
      axr(8'(i * 4));
      `CK(d, 32'(m[i]))
      `CK(r, (i == 7 || i == 15) ? ERR_R : OK_R)
    end
  endtask

  task automatic xc(input logic [3:0] s, input logic [1:0] z, input logic [31:0] w,
                    input logic [7:0] a, input logic [31:0] e);
    cpurf_exec_model_i.wr(s, z, w);
    rchk(a, e);
  endtask

  task automatic ac(input logic [3:0] k, input logic [1:0] z, input logic [31:0] w,
                    input logic c, input logic o, input logic [31:0] e);
    cpurf_exec_model_i.alu(k, z, w, c, o);
    rchk(8'h54, e);
  endtask

  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      conclude();
    end
  end

  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    rs = 16'h8654;  // 34388
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    sweep();
    for (int i = 0; i < 22; i++)
    begin
      rs = nx(rs);
      v = {rs, ~rs} & ~32'h2;
      axw(8'(i * 4), v);
      `CK(r, (i == 7 || i == 15) ? ERR_R : OK_R)
      if (i != 7 && i != 15)
        m[i] = v & wmask(i);
    end
    sweep();
    `CK(pc_value, m[17][19:0])
    `CK(vtb_value, m[16][19:0])
    axw(8'h54, 32'h0);
    xc(4'hb, 2'h0, 32'h10, 8'h54, 32'h10);
    xc(4'h0, 2'h0, 32'hbeef, 8'h20, 32'hbeef);
    rchk(8'h00, m[0]);
    xc(4'h0, 2'h2, 32'h5a, 8'h20, 32'h5aef);
    xc(4'h0, 2'h1, 32'ha5, 8'h20, 32'h5aa5);
    cpurf_exec_model_i.rd(4'h0, 2'h2, d);
    `CK(d, 32'h5a)
    xc(4'h0, 2'h3, 32'h11112222, 8'h28, 32'h1111);
    xc(4'h1, 2'h3, 32'h55556666, 8'h2c, 32'h5555);
    cpurf_exec_model_i.rd(4'h0, 2'h3, d);
    `CK(d, 32'h11112222)
    xc(4'h4, 2'h3, 32'h33334444, 8'h34, 32'h3333);
    cpurf_exec_model_i.rd(4'h4, 2'h3, d);
    `CK(d, 32'h33334444)
    xc(4'h4, 2'h3, 32'h7777aaaa, 8'h30, 32'haaaa);
    xc(4'h6, 2'h0, 32'h6666, 8'h38, 32'h6666);
    xc(4'h7, 2'h0, 32'h7777, 8'h50, 32'h7777);
    xc(4'h9, 2'h0, 32'h12345, 8'h40, 32'h12345);
    xc(4'ha, 2'h0, 32'habcde, 8'h44, 32'habcde);
    xc(4'hb, 2'h0, 32'h90, 8'h54, 32'h90);
    xc(4'h8, 2'h0, 32'h1234, 8'h48, 32'h1234);
    xc(4'hb, 2'h0, 32'h10, 8'h54, 32'h10);
    xc(4'h8, 2'h0, 32'h4321, 8'h4c, 32'h4321);
    axw(8'h54, 32'h0);
    ac(4'hf, 2'h0, 32'h0, 1'b1, 1'b0, 32'h005);
    ac(4'hf, 2'h0, 32'h8000, 1'b0, 1'b1, 32'h028);
    ac(4'hf, 2'h3, 32'h8000, 1'b0, 1'b0, 32'h000);
    ac(4'hf, 2'h1, 32'h0180, 1'b1, 1'b0, 32'h009);
    ac(4'h1, 2'h0, 32'h1, 1'b0, 1'b1, 32'h008);
    axw(8'h54, 32'h3c0);
    cpurf_exec_model_i.lvl(3'h4);
    `CK(irq_enabled, 1'b1)
    cpurf_exec_model_i.lvl(3'h3);
    `CK(irq_enabled, 1'b0)
    rchk(8'h58, 32'h2);
    cpurf_exec_model_i.lvl(3'h4);
    cpurf_exec_model_i.pulse(1'b1, 1'b0, 6'h00);
    rchk(8'h54, 32'h300);
    `CK(irq_enabled, 1'b0)
    axw(8'h54, 32'h380);
    cpurf_exec_model_i.pulse(1'b0, 1'b1, 6'h20);
    rchk(8'h54, 32'h380);
    cpurf_exec_model_i.pulse(1'b0, 1'b1, 6'h1f);
    rchk(8'h54, 32'h300);
    conclude();
  end
endmodule
